// ### design/dmr_defs.vh
// Constants for the mode register bank at addresses 07h to 0Ch
`ifndef DMR_DEFS_VH
`define DMR_DEFS_VH

`define DMR_ADDR_REVISION 6'h07
`define DMR_ADDR_CONFIG 6'h08
`define DMR_ADDR_TEST 6'h09
`define DMR_ADDR_CALRST 6'h0A
`define DMR_ADDR_TERM 6'h0B
`define DMR_ADDR_CAREF 6'h0C

// Arbitrary revision code, no meaning beyond this model
`define DMR_REVISION_CODE 8'h5A
`define DMR_TYPE_S16 2'h0
`define DMR_DENSITY_8GB 4'h4
`define DMR_WIDTH_X16 2'h0
`define DMR_WIDTH_X8 2'h1

`define DMR_TERM_RSVD 3'h7
`define DMR_TERM_RESET 3'h0
`define DMR_TERM_DQ_LSB 0
`define DMR_TERM_CA_LSB 4
`define DMR_LEVEL_MAX 6'h32
`define DMR_CAREF_RESET 8'h4D
`define DMR_LEVEL_RESET 6'h0D
`define DMR_RANGE_BIT 6
`define DMR_VARIANT_BIT 7

// Settle wait: base plus per-code step, in ns, converted at 100 ns per cycle
`define DMR_CLK_NS 100
`define DMR_SETTLE_BASE_NS 200
`define DMR_SETTLE_STEP_NS 100
`define DMR_SETTLE_BASE_CYC ((`DMR_SETTLE_BASE_NS + `DMR_CLK_NS - 1) / `DMR_CLK_NS)
`define DMR_SETTLE_STEP_CYC ((`DMR_SETTLE_STEP_NS + `DMR_CLK_NS - 1) / `DMR_CLK_NS)

`endif

// ### design/dmr_setpoint_copy.v
// One pair of set point copies with write and active selection
`timescale 1ns/1ns
`default_nettype none
module dmr_setpoint_copy #(
    parameter W = 8,
    parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
    input wire clk_sys, // System clock
    input wire rst, // Synchronous reset, high
    input wire wrEn, // Write strobe for this field
    input wire [W-1:0] wrData, // Value to store
    input wire wrSel, // Write set point select
    input wire actSel, // Active set point select
    output wire [W-1:0] wrView, // Copy picked by write select
    output wire [W-1:0] actView // Copy used by operation
);
    reg [W-1:0] copy0_ff;
    reg [W-1:0] copy1_ff;

    always @(posedge clk_sys) begin
        if (rst) begin
            copy0_ff <= RESET_VAL;
            copy1_ff <= RESET_VAL;
        end else if (wrEn) begin
            if (wrSel) begin
                copy1_ff <= wrData;
            end else begin
                copy0_ff <= wrData;
            end
        end
    end

    assign wrView = wrSel ? copy1_ff : copy0_ff;
    // Inactive copy never reaches operation, so it may be prepared ahead
    assign actView = actSel ? copy1_ff : copy0_ff;
endmodule // dmr_setpoint_copy
`default_nettype wire

// ### design/dmr_settle_timer.v
// Reference settle timer, wait grows with step size
`timescale 1ns/1ns
`default_nettype none
`include "dmr_defs.vh"
module dmr_settle_timer (
    input wire clk_sys, // System clock
    input wire rst, // Synchronous reset, high
    input wire start, // Active level changed
    input wire [5:0] oldLevel, // Level before change
    input wire [5:0] newLevel, // Level after change
    output wire settling // High while level settles
);
    reg [7:0] count_ff;
    reg [7:0] nxt_count;
    wire [5:0] stepSize;
    // Base wait kept as an integer, then trimmed to the counter width on purpose
    localparam integer BASE_CYC_INT = `DMR_SETTLE_BASE_CYC;
    localparam [7:0] BASE_CYC = BASE_CYC_INT[7:0];

    assign stepSize = (newLevel > oldLevel) ? (newLevel - oldLevel) : (oldLevel - newLevel);

    always @* begin
        nxt_count = count_ff;
        if (start) begin
            nxt_count = BASE_CYC + {2'h0, stepSize};
        end else if (count_ff != 8'h00) begin
            nxt_count = count_ff - 8'h01;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            count_ff <= 8'h00;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign settling = (count_ff != 8'h00);
endmodule // dmr_settle_timer
`default_nettype wire

// ### design/dmr_mode_regs.v
// Mode register bank for addresses 07h to 0Ch of one channel
`timescale 1ns/1ns
`default_nettype none
`include "dmr_defs.vh"
module dmr_mode_regs (
    input wire clk_sys, // System clock, 10 MHz
    input wire rst, // Synchronous reset, high
    input wire modeWrite, // Mode register write command pulse
    input wire modeRead, // Mode register read command pulse
    input wire [5:0] modeRegAddr, // Mode register address
    input wire [7:0] operandBits, // Write operand
    input wire writeSetpointSelect, // Selects copies reached by access
    input wire activeSetpointSelect, // Selects copies used by operation
    input wire calPinGrounded, // Calibration pin strapped to ground
    input wire byteModeX8, // Device runs in eight-bit byte mode
    output reg [7:0] readData, // Read data on data lines 7:0
    output reg readValid, // Read data valid pulse
    output reg impedanceCalReset, // Reset calibration to default pulse
    output wire calDefaultMode, // Calibration held at default values
    output wire [2:0] dataTerminationSel, // Active data termination
    output wire [2:0] cmdTerminationSel, // Active command termination
    output wire [5:0] caReferenceLevel, // Active reference level
    output wire caReferenceRange, // Active reference range
    output wire commandTrainingVariant, // Effective training variant
    output wire caRefSettling, // Reference level still settling
    output reg [7:0] vendorTest // Last test register value
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire wrTerm;
    wire wrCaRef;
    wire wrCal;
    wire wrTest;
    wire [2:0] dqField;
    wire [2:0] caField;
    wire [7:0] caRefWrCopy;
    wire [7:0] caRefActive;
    wire [7:0] caRefMerged;
    wire [7:0] configValue;
    reg [7:0] nxt_readData;
    reg [5:0] prevLevel_ff;

    assign wrTerm = modeWrite && (modeRegAddr == `DMR_ADDR_TERM);
    assign wrCaRef = modeWrite && (modeRegAddr == `DMR_ADDR_CAREF);
    assign wrCal = modeWrite && (modeRegAddr == `DMR_ADDR_CALRST);
    assign wrTest = modeWrite && (modeRegAddr == `DMR_ADDR_TEST);

    // ----------------------------------------------------------------
    // Termination copies
    // ----------------------------------------------------------------
    // Reserved code is dropped: the stored copy keeps its old value
    assign dqField = operandBits[`DMR_TERM_DQ_LSB +: 3];
    assign caField = operandBits[`DMR_TERM_CA_LSB +: 3];

    dmr_setpoint_copy #(.W(3), .RESET_VAL(`DMR_TERM_RESET)) uDqTerm (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(wrTerm && (dqField != `DMR_TERM_RSVD)),
        .wrData(dqField),
        .wrSel(writeSetpointSelect),
        .actSel(activeSetpointSelect),
        .wrView(), // Write-only field, never read back
        .actView(dataTerminationSel)
    );

    dmr_setpoint_copy #(.W(3), .RESET_VAL(`DMR_TERM_RESET)) uCaTerm (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(wrTerm && (caField != `DMR_TERM_RSVD)),
        .wrData(caField),
        .wrSel(writeSetpointSelect),
        .actSel(activeSetpointSelect),
        .wrView(), // Write-only field, never read back
        .actView(cmdTerminationSel)
    );

    // ----------------------------------------------------------------
    // Reference register copies
    // ----------------------------------------------------------------
    // A reserved level code keeps the old level but range and variant still update
    assign caRefMerged = {operandBits[`DMR_VARIANT_BIT], operandBits[`DMR_RANGE_BIT],
        (operandBits[5:0] > `DMR_LEVEL_MAX) ? caRefWrCopy[5:0] : operandBits[5:0]};

    dmr_setpoint_copy #(.W(8), .RESET_VAL(`DMR_CAREF_RESET)) uCaRef (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(wrCaRef),
        .wrData(caRefMerged),
        .wrSel(writeSetpointSelect),
        .actSel(activeSetpointSelect),
        .wrView(caRefWrCopy),
        .actView(caRefActive)
    );

    assign caReferenceLevel = caRefActive[5:0];
    assign caReferenceRange = caRefActive[`DMR_RANGE_BIT];
    // Variant two only has meaning on an x8 device
    assign commandTrainingVariant = caRefActive[`DMR_VARIANT_BIT] & byteModeX8;

    // Settle timing follows the active level, whichever way it changed
    always @(posedge clk_sys) begin
        if (rst) begin
            prevLevel_ff <= `DMR_LEVEL_RESET;
        end else begin
            prevLevel_ff <= caRefActive[5:0];
        end
    end

    dmr_settle_timer uSettle (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(prevLevel_ff != caRefActive[5:0]),
        .oldLevel(prevLevel_ff),
        .newLevel(caRefActive[5:0]),
        .settling(caRefSettling)
    );

    // ----------------------------------------------------------------
    // Calibration reset and test register
    // ----------------------------------------------------------------
    assign calDefaultMode = calPinGrounded;

    always @(posedge clk_sys) begin
        if (rst) begin
            impedanceCalReset <= 1'b0;
            vendorTest <= 8'h00;
        end else begin
            // Grounded pin: the command is dropped, default values already apply
            impedanceCalReset <= wrCal && operandBits[0] && !calPinGrounded;
            if (wrTest) begin
                vendorTest <= operandBits;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign configValue = {(byteModeX8 ? `DMR_WIDTH_X8 : `DMR_WIDTH_X16),
        `DMR_DENSITY_8GB,
        `DMR_TYPE_S16};

    always @* begin
        nxt_readData = 8'h00;
        case (modeRegAddr)
            `DMR_ADDR_REVISION: nxt_readData = `DMR_REVISION_CODE;
            `DMR_ADDR_CONFIG: nxt_readData = configValue;
            `DMR_ADDR_CAREF: nxt_readData = caRefWrCopy;
            default: nxt_readData = 8'h00; // Write-only and unmapped read as zero
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            readData <= 8'h00;
            readValid <= 1'b0;
        end else begin
            readValid <= modeRead;
            if (modeRead) begin
                readData <= nxt_readData;
            end
        end
    end

endmodule // dmr_mode_regs
`default_nettype wire

// ### test/dmr_mode_regs_properties.sv
// Assertions for the mode register bank
`timescale 1ns/1ns
`default_nettype none
`include "dmr_defs.vh"
module dmr_mode_regs_properties (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic modeWrite, // write
    input wire logic modeRead, // read
    input wire logic [5:0] modeRegAddr, // address
    input wire logic [7:0] operandBits, // operand
    input wire logic writeSetpointSelect, // write copy
    input wire logic activeSetpointSelect, // active copy
    input wire logic calPinGrounded, // cal pin
    input wire logic byteModeX8, // x8 mode
    input wire logic [7:0] readData, // read data
    input wire logic readValid, // valid
    input wire logic impedanceCalReset, // cal reset
    input wire logic calDefaultMode, // cal default
    input wire logic [2:0] dataTerminationSel, // dq term
    input wire logic [2:0] cmdTerminationSel, // ca term
    input wire logic [5:0] caReferenceLevel, // level
    input wire logic caReferenceRange, // range
    input wire logic commandTrainingVariant, // variant
    input wire logic caRefSettling, // settling
    input wire logic [7:0] vendorTest // test reg
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_read_valid: assert property (modeRead |=> readValid)
        else $error("read without valid");
    a_config_value: assert property (
        modeRead && modeRegAddr == 6'h08 |=> readData == {1'b0, $past(byteModeX8), 6'h10})
        else $error("config report wrong");
    a_rev_fixed: assert property (
        modeRead && modeRegAddr == 6'h07 |=> readData == `DMR_REVISION_CODE)
        else $error("revision code wrong");
    a_cal_pulse: assert property (
        modeWrite && modeRegAddr == 6'h0A && operandBits[0] && !calPinGrounded
        |=> impedanceCalReset) else $error("no cal reset pulse");
    a_cal_ignored: assert property (calPinGrounded |=> !impedanceCalReset)
        else $error("cal reset while grounded");
    a_term_reserved: assert property (
        modeWrite && modeRegAddr == 6'h0B && operandBits[2:0] == 3'h7
        |=> !$stable(activeSetpointSelect) || $stable(dataTerminationSel))
        else $error("reserved term code taken");
    a_caterm_reserved: assert property (
        modeWrite && modeRegAddr == 6'h0B && operandBits[6:4] == 3'h7
        |=> !$stable(activeSetpointSelect) || $stable(cmdTerminationSel))
        else $error("reserved command term code taken");
    a_level_reserved: assert property (
        modeWrite && modeRegAddr == 6'h0C && operandBits[5:0] > 6'h32
        |=> !$stable(activeSetpointSelect) || $stable(caReferenceLevel))
        else $error("reserved level code taken");
    a_inactive_hold: assert property (
        modeWrite && writeSetpointSelect != activeSetpointSelect
        |=> !$stable(activeSetpointSelect) || $stable({dataTerminationSel,
        cmdTerminationSel, caReferenceRange, caReferenceLevel}))
        else $error("inactive write changed operation");
    a_variant_x8: assert property (!byteModeX8 |-> !commandTrainingVariant)
        else $error("variant outside x8");
    a_settle_start: assert property ($changed(caReferenceLevel) |=> caRefSettling)
        else $error("no settle after level change");
    c_caref_read: cover property (modeRead && modeRegAddr == 6'h0C);
    c_cal_reset: cover property (impedanceCalReset);
    c_settle_end: cover property ($fell(caRefSettling));
endmodule // dmr_mode_regs_properties

bind dmr_mode_regs dmr_mode_regs_properties u_dmr_mode_regs_properties (.*);
`default_nettype wire

// ### test/dmr_ctrl_model.sv
// Controller model issuing mode register commands
`timescale 1ns/1ns
`default_nettype none
module dmr_ctrl_model (
    input wire logic clk_sys, // clock
    output logic modeWrite, // write
    output logic modeRead, // read
    output logic [5:0] modeRegAddr, // address
    output logic [7:0] operandBits, // operand
    output logic writeSetpointSelect, // write copy
    output logic activeSetpointSelect // active copy
);
    initial begin
        {modeWrite, modeRead, writeSetpointSelect, activeSetpointSelect} = 4'h0;
        modeRegAddr = 6'h3F;
        operandBits = 8'h00;
    end
    // -------------
    // Command tasks
    // -------------
    // Idle lines flip so a stale address is never mistaken for a live one
    task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        {modeWrite, modeRead, modeRegAddr, operandBits} = {wr, !wr, a, d};
        @(posedge clk_sys);
        #1;
        {modeWrite, modeRead, modeRegAddr, operandBits} = {2'h0, ~a, ~d};
    endtask
    task automatic setsp(input logic w, input logic o);
        @(posedge clk_sys);
        #1;
        {writeSetpointSelect, activeSetpointSelect} = {w, o};
        #1;
    endtask
endmodule // dmr_ctrl_model
`default_nettype wire

// ### test/dmr_mode_regs_test.sv
// Testbench for the mode register bank
`timescale 1ns/1ns
`default_nettype none
`include "dmr_defs.vh"
module dmr_mode_regs_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic calPinGrounded = 1'b0;
    logic byteModeX8 = 1'b0;
    logic modeWrite, modeRead, writeSetpointSelect, activeSetpointSelect;
    logic [5:0] modeRegAddr, caReferenceLevel;
    logic [7:0] operandBits, readData, vendorTest;
    logic [2:0] dataTerminationSel, cmdTerminationSel;
    logic readValid, impedanceCalReset, calDefaultMode, caReferenceRange;
    logic commandTrainingVariant, caRefSettling;
    int err_count = 0;
    int compares = 0;
    wire [7:0] term = {1'b0, cmdTerminationSel, 1'b0, dataTerminationSel};
    wire [7:0] caref = {commandTrainingVariant, caReferenceRange, caReferenceLevel};
    always #50 clk_sys = ~clk_sys;
    dmr_mode_regs u_dmr_mode_regs (.*);
    dmr_ctrl_model u_dmr_ctrl_model (.*);
    // ---------
    // Scenarios
    // ---------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_dmr_ctrl_model.cmd(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        u_dmr_ctrl_model.cmd(1'b0, a, 8'h00);
        chk({7'h00, readValid}, 8'h01);
        chk(readData, exp);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
    endtask
    task automatic t_ids;
        wr(6'h08, 8'hFF);
        wr(6'h07, 8'h00);
        rd(6'h08, 8'h10);
        byteModeX8 = 1'b1;
        rd(6'h08, 8'h50);
        rd(6'h07, `DMR_REVISION_CODE);
        rd(6'h0B, 8'h00);
        rd(6'h3F, 8'h00);
        rd(6'h0C, 8'h4D);
    endtask
    task automatic t_cal;
        wr(6'h0A, 8'h01);
        chk({7'h00, impedanceCalReset}, 8'h01);
        wr(6'h0A, 8'h00);
        chk({7'h00, impedanceCalReset}, 8'h00);
        calPinGrounded = 1'b1;
        wr(6'h0A, 8'h01);
        chk({6'h00, calDefaultMode, impedanceCalReset}, 8'h02);
        calPinGrounded = 1'b0;
        wr(6'h09, 8'h00);
        chk(vendorTest, 8'h00);
    endtask
    task automatic t_term;
        for (int c = 0; c < 7; c++) begin
            wr(6'h0B, {1'b0, 3'(6 - c), 1'b0, 3'(c)});
            chk(term, {1'b0, 3'(6 - c), 1'b0, 3'(c)});
        end
        wr(6'h0B, 8'h77);
        chk(term, 8'h06);
        // One reserved field must not block the other field of the same write
        wr(6'h0B, 8'h17);
        chk(term, 8'h16);
        wr(6'h0B, 8'h71);
        chk(term, 8'h11);
    endtask
    task automatic t_fsp;
        u_dmr_ctrl_model.setsp(1'b1, 1'b0);
        wr(6'h0B, 8'h25);
        chk(term, 8'h11);
        wr(6'h0C, 8'h20);
        chk(caref, 8'h4D);
        rd(6'h0C, 8'h20);
        u_dmr_ctrl_model.setsp(1'b1, 1'b1);
        chk(term, 8'h25);
        chk(caref, 8'h20);
        u_dmr_ctrl_model.setsp(1'b0, 1'b1);
        rd(6'h0C, 8'h4D);
    endtask
    task automatic t_caref;
        u_dmr_ctrl_model.setsp(1'b0, 1'b0);
        wr(6'h0C, 8'h8A);
        chk(caref, 8'h8A);
        byteModeX8 = 1'b0;
        #1;
        chk(caref, 8'h0A);
        wr(6'h0C, 8'hF3);
        chk(caref, 8'h4A);
        rd(6'h0C, 8'hCA);
    endtask
    task automatic t_settle;
        logic [7:0] n = 8'h00;
        for (int i = 0; i < 100 && caRefSettling; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({7'h00, caRefSettling}, 8'h00);
        wr(6'h0C, 8'h72);
        repeat (60) begin
            @(posedge clk_sys);
            #1;
            n = n + {7'h00, caRefSettling};
        end
        chk(n, 8'h2A);
        do_reset;
        rd(6'h0C, 8'h4D);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        do_reset;
        t_ids;
        t_cal;
        t_term;
        t_fsp;
        t_caref;
        t_settle;
        close_out;
    end
    // The whole run needs about 160 cycles; allow several times that
    initial begin
        #200000;
        err_count++;
        close_out;
    end
endmodule // dmr_mode_regs_test
`default_nettype wire
